// ===== hdl/shaper_regs_params.svh
// Offsets, field positions, reset values and the unlimited and 10M maximum rate codes for the port shaper registers
`ifndef SHAPER_REGS_PARAMS_SVH
`define SHAPER_REGS_PARAMS_SVH
`define OFF_P1_SHAPING   8'h19
`define OFF_P1_PHY_SPCL  8'h1a
`define OFF_P1_DIAG_RES  8'h1b
`define OFF_P2_SHAPING   8'h29
`define OFF_P2_PHY_SPCL  8'h2a
`define OFF_P2_DIAG_RES  8'h2b
`define OFF_P3_SHAPING   8'h39
`define OFF_P3_RSVD      8'h3a
`define SHP_CLS3_MSB     7
`define SHP_CLS3_LSB     4
`define SHP_CLS2_MSB     3
`define SHP_CLS2_LSB     0
`define SHP_RESET        8'h00
`define PHY_SHORT_BIT    7
`define PHY_RES_MSB      6
`define PHY_RES_LSB      5
`define PHY_START_BIT    4
`define PHY_FLINK_BIT    3
`define PHY_PSAVE_BIT    2
`define PHY_RLOOP_BIT    1
`define PHY_DIST8_BIT    0
`define PHY_RESET        8'h04
`define DIAG_RESET       8'h00
`define RATE_CODE_UNLIM  4'h0
`define RATE_CODE_10M_MAX 4'h8
`endif

// ===== hdl/shaper_regs_pkg.sv
// Types shared by the port shaper and cable test register block
package shaper_regs_pkg;
   typedef enum logic [1:0] {CT_NORMAL, CT_OPEN, CT_SHORT, CT_FAIL} cable_result_t;
   typedef enum {DG_IDLE, DG_RUN} diag_state_t;
endpackage

// ===== hdl/rate_decode.sv
// Maps a 4-bit egress limit code to a rate in kbit/s, applying speed and queue mode
`timescale 1ns/1ps
`default_nettype none
`include "shaper_regs_params.svh"
module rate_decode
   import shaper_regs_pkg::*;
(
   input  wire logic [3:0]  code,
   input  wire logic        speed_10m,
   input  wire logic        queue_active,
   output logic [16:0]      rate_kbps
);
   logic [3:0] eff;
   always_comb
   begin
      eff = code;
      if (!queue_active)
         eff = `RATE_CODE_UNLIM;
      else if (speed_10m && (code > `RATE_CODE_10M_MAX))
         eff = `RATE_CODE_UNLIM;
      case (eff)
         4'h1: rate_kbps = 17'd64;
         4'h2: rate_kbps = 17'd128;
         4'h3: rate_kbps = 17'd256;
         4'h4: rate_kbps = 17'd512;
         4'h5: rate_kbps = 17'd1000;
         4'h6: rate_kbps = 17'd2000;
         4'h7: rate_kbps = 17'd4000;
         4'h8: rate_kbps = 17'd8000;
         4'h9: rate_kbps = 17'd16000;
         4'ha: rate_kbps = 17'd32000;
         4'hb: rate_kbps = 17'd48000;
         4'hc: rate_kbps = 17'd64000;
         4'hd: rate_kbps = 17'd72000;
         4'he: rate_kbps = 17'd80000;
         4'hf: rate_kbps = 17'd88000;
         default: rate_kbps = 17'd0;
      endcase
   end
endmodule
`default_nettype wire

// ===== hdl/port_shaper_regs.sv
// Per-port egress shaping limits and PHY special control/status registers
`timescale 1ns/1ps
`default_nettype none
`include "shaper_regs_params.svh"
//////////////////////////////////////////////////////////////////////////////
module port_shaper_regs
   import shaper_regs_pkg::*;
#(
   parameter int NPORT = 3,
   parameter int NPHY  = 2
)
(
   input  wire logic                 clk,
   input  wire logic                 rstn,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic [7:0]                reg_rdata,
   input  wire logic [NPHY-1:0]      miim_wr,
   input  wire logic [NPHY*8-1:0]    miim_wdata,
   output logic [NPHY*8-1:0]         miim_rdata,
   input  wire logic                 multi_queue_en,
   input  wire logic [NPORT-1:0]     port_speed_10m,
   output logic [NPORT*17-1:0]       class3_rate_kbps,
   output logic [NPORT*17-1:0]       class2_rate_kbps,
   output logic [NPHY-1:0]           diag_start,
   input  wire logic [NPHY-1:0]      diag_done,
   input  wire logic [NPHY*2-1:0]    diag_result,
   input  wire logic [NPHY-1:0]      diag_near_short,
   input  wire logic [NPHY*9-1:0]    diag_fault_count,
   output logic [NPHY-1:0]           force_link_pass,
   output logic [NPHY-1:0]           power_save_en,
   output logic [NPHY-1:0]           remote_loopback
);
   typedef struct packed {
      logic [NPORT-1:0][7:0] shp;
      logic [NPHY-1:0][7:0]  phy;
      logic [NPHY-1:0][7:0]  dres;
      diag_state_t [NPHY-1:0] dst;
      logic [7:0]            rdata;
      logic [NPHY-1:0][7:0]  mrdata;
      logic [NPORT-1:0][16:0] r3;
      logic [NPORT-1:0][16:0] r2;
      logic [NPHY-1:0]       start;
      logic [NPHY-1:0]       psave;
   } state_t;

   state_t s_q, s_d;
   logic [NPORT-1:0][16:0] r3_w, r2_w;
   logic [7:0] shp_off [NPORT];
   logic [7:0] phy_off [NPHY];
   logic [7:0] dres_off [NPHY];

   //////////////////////////////////////////////////////////////////////////
   // Rate decode per port and queue
   // Each limit is decoded against its port's speed and the queue mode
   genvar g;
   generate
      for (g = 0; g < NPORT; g++)
      begin : g_rate
         rate_decode u_r3 (
            .code         (s_q.shp[g][`SHP_CLS3_MSB:`SHP_CLS3_LSB]),
            .speed_10m    (port_speed_10m[g]),
            .queue_active (multi_queue_en),
            .rate_kbps    (r3_w[g])
         );
         rate_decode u_r2 (
            .code         (s_q.shp[g][`SHP_CLS2_MSB:`SHP_CLS2_LSB]),
            .speed_10m    (port_speed_10m[g]),
            .queue_active (multi_queue_en),
            .rate_kbps    (r2_w[g])
         );
      end
   endgenerate

   // Offset tables; port 3 has only its shaping register
   assign shp_off[0] = `OFF_P1_SHAPING;
   assign shp_off[1] = `OFF_P2_SHAPING;
   assign shp_off[2] = `OFF_P3_SHAPING;
   assign phy_off[0] = `OFF_P1_PHY_SPCL;
   assign phy_off[1] = `OFF_P2_PHY_SPCL;
   assign dres_off[0] = `OFF_P1_DIAG_RES;
   assign dres_off[1] = `OFF_P2_DIAG_RES;

   //////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      logic [7:0] wv;
      logic       wen;
      wv  = 8'h00;
      wen = 1'b0;
      s_d = s_q;
      s_d.r3 = r3_w;
      s_d.r2 = r2_w;
      s_d.rdata = 8'h00;
      // Read data stands one cycle after the strobe and is zero otherwise
      // Shaping registers of all three ports
      for (int p = 0; p < NPORT; p++)
      begin
         if (reg_wr && reg_addr == shp_off[p])
            s_d.shp[p] = reg_wdata;
         if (reg_rd && reg_addr == shp_off[p])
            s_d.rdata = s_q.shp[p];
      end
      for (int p = 0; p < NPHY; p++)
      begin
         // Control/status and fault count low byte of the two copper ports
         // Register bus write wins over a same-cycle management write
         wen = (reg_wr && reg_addr == phy_off[p]) || miim_wr[p];
         wv  = (reg_wr && reg_addr == phy_off[p]) ? reg_wdata : miim_wdata[p*8 +: 8];
         // Only the control bits follow a write; result bits keep their values
         if (wen)
         begin
            s_d.phy[p][`PHY_FLINK_BIT] = wv[`PHY_FLINK_BIT];
            s_d.phy[p][`PHY_PSAVE_BIT] = wv[`PHY_PSAVE_BIT];
            s_d.phy[p][`PHY_RLOOP_BIT] = wv[`PHY_RLOOP_BIT];
         end
         // A start is taken only while idle; writes during a run neither restart nor stop it
         case (s_q.dst[p])
            DG_IDLE:
            begin
               if (wen && wv[`PHY_START_BIT])
               begin
                  s_d.phy[p][`PHY_START_BIT] = 1'b1;
                  s_d.dst[p] = DG_RUN;
               end
            end
            DG_RUN:
            begin
               // Results are latched only on the done pulse that ends a run
               if (diag_done[p])
               begin
                  s_d.phy[p][`PHY_START_BIT] = 1'b0;
                  s_d.phy[p][`PHY_SHORT_BIT] = diag_near_short[p];
                  s_d.phy[p][`PHY_RES_MSB:`PHY_RES_LSB] = diag_result[p*2 +: 2];
                  s_d.phy[p][`PHY_DIST8_BIT] = diag_fault_count[p*9+8];
                  s_d.dres[p] = diag_fault_count[p*9 +: 8];
                  s_d.dst[p] = DG_IDLE;
               end
            end
            default:
               // Recover an illegal state to idle
               s_d.dst[p] = DG_IDLE;
         endcase
         // Test request to the PHY stays high for the whole run
         s_d.start[p] = (s_d.dst[p] == DG_RUN);
         // Power save enable has its own flop so the pin needs no inverter
         s_d.psave[p] = ~s_d.phy[p][`PHY_PSAVE_BIT];
         // Management side sees the register as it stands after this edge
         s_d.mrdata[p] = s_d.phy[p];
         if (reg_rd && reg_addr == phy_off[p])
            s_d.rdata = s_q.phy[p];
         if (reg_rd && reg_addr == dres_off[p])
            s_d.rdata = s_q.dres[p];
      end
      // Any other unmapped offset also reads zero
      // Reserved slot of port 3 reads zero and ignores writes
      if (reg_rd && reg_addr == `OFF_P3_RSVD)
         s_d.rdata = 8'h00;
      // Synchronous reset; power saving starts disabled
      if (!rstn)
      begin
         s_d = '0;
         for (int p = 0; p < NPORT; p++)
         begin
            s_d.shp[p] = `SHP_RESET;
         end
         for (int p = 0; p < NPHY; p++)
         begin
            s_d.phy[p]    = `PHY_RESET;
            s_d.psave[p]  = 1'b0;
            s_d.dres[p]   = `DIAG_RESET;
            s_d.mrdata[p] = `PHY_RESET;
            s_d.dst[p]    = DG_IDLE;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   //////////////////////////////////////////////////////////////////////////
   // Outputs straight from state
   // Rates follow a code or mode change by one cycle
   assign reg_rdata  = s_q.rdata;
   assign miim_rdata = s_q.mrdata;
   assign diag_start = s_q.start;
   generate
      for (g = 0; g < NPORT; g++)
      begin : g_out
         assign class3_rate_kbps[g*17 +: 17] = s_q.r3[g];
         assign class2_rate_kbps[g*17 +: 17] = s_q.r2[g];
      end
      for (g = 0; g < NPHY; g++)
      begin : g_phy
         // Link pass and loopback drive the PHY straight from their bits
         assign force_link_pass[g] = s_q.phy[g][`PHY_FLINK_BIT];
         assign power_save_en[g]   = s_q.psave[g];
         assign remote_loopback[g] = s_q.phy[g][`PHY_RLOOP_BIT];
      end
   endgenerate
endmodule
`default_nettype wire

// ===== bench/port_shaper_regs_chk.sv
// Checker bound to the port shaper register block
`timescale 1ns/1ps
`default_nettype none
module port_shaper_regs_chk #(parameter int NPORT = 3, parameter int NPHY = 2)
(
   input wire logic                 clk,
   input wire logic                 rstn,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [7:0]           reg_addr,
   input wire logic [7:0]           reg_wdata,
   input wire logic [7:0]           reg_rdata,
   input wire logic [NPHY*8-1:0]    miim_rdata,
   input wire logic                 multi_queue_en,
   input wire logic [NPORT*17-1:0]  class3_rate_kbps,
   input wire logic [NPORT*17-1:0]  class2_rate_kbps,
   input wire logic [NPHY-1:0]      diag_start,
   input wire logic [NPHY-1:0]      diag_done,
   input wire logic [NPHY*2-1:0]    diag_result,
   input wire logic [NPHY-1:0]      power_save_en,
   input wire logic [NPHY-1:0]      remote_loopback
);
   wire logic wr1 = reg_wr && reg_addr == 8'h1a;
   wire logic run_end = diag_start[0] && diag_done[0];
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   //////////////////////////////////////////
   property p_go; wr1 && reg_wdata[4] && !diag_start[0] |=> diag_start[0]; endproperty
   a_go: assert property (p_go) else $error("test did not start");
   property p_hold; diag_start[0] && !diag_done[0] |=> diag_start[0]; endproperty
   a_hold: assert property (p_hold) else $error("test ended early");
   property p_end; run_end |=> !diag_start[0]; endproperty
   a_end: assert property (p_end) else $error("start bit not cleared");
   property p_cap; run_end |=> miim_rdata[6:5] == $past(diag_result[1:0]); endproperty
   a_cap: assert property (p_cap) else $error("outcome not captured");
   property p_ro; !run_end |=> $stable(miim_rdata[7:5]); endproperty
   a_ro: assert property (p_ro) else $error("result bits changed");
   property p_pwr; wr1 |=> power_save_en[0] == !$past(reg_wdata[2]); endproperty
   a_pwr: assert property (p_pwr) else $error("power save wrong");
   property p_lb; wr1 |=> remote_loopback[0] == $past(reg_wdata[1]); endproperty
   a_lb: assert property (p_lb) else $error("loopback bit wrong");
   property p_mq; !multi_queue_en |=> class3_rate_kbps == '0 && class2_rate_kbps == '0; endproperty
   a_mq: assert property (p_mq) else $error("single queue rate not zero");
   property p_rsv; reg_rd && reg_addr == 8'h3a |=> reg_rdata == 8'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved slot not zero");
   c_run: cover property (run_end);
   c_rsv: cover property (reg_rd && reg_addr == 8'h3a);
   c_lb: cover property (wr1 && reg_wdata[1]);
endmodule
bind port_shaper_regs port_shaper_regs_chk #(.NPORT(NPORT), .NPHY(NPHY)) chk_i (.clk, .rstn,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .miim_rdata, .multi_queue_en,
   .class3_rate_kbps, .class2_rate_kbps, .diag_start, .diag_done, .diag_result,
   .power_save_en, .remote_loopback);
`default_nettype wire

// ===== bench/port_shaper_regs_tb.sv
// Directed register tests for the port shaper register block
`timescale 1ns/1ps
`default_nettype none
module port_shaper_regs_tb;
   logic        clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mq = 1'b1;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
   logic [1:0]  mwr = 2'h0, done = 2'h0, nshort = 2'h0;
   logic [15:0] mwdata = 16'h0000;
   logic [2:0]  spd = 3'h0;
   logic [3:0]  res = 4'h0;
   logic [17:0] fcnt = 18'h00000;
   logic [50:0] c3, c2;
   logic [15:0] mrd;
   logic [1:0]  dgs, flp, pse, rlb;
   logic [16:0] e;
   int          n_errors = 0, checks = 0;
   logic [16:0] rt [16] = '{17'h0, 17'h40, 17'h80, 17'h100, 17'h200, 17'h3e8, 17'h7d0,
      17'hfa0, 17'h1f40, 17'h3e80, 17'h7d00, 17'hbb80, 17'hfa00, 17'h11940, 17'h13880,
      17'h157c0};
   port_shaper_regs DUT (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .miim_wr(mwr),
      .miim_wdata(mwdata), .miim_rdata(mrd), .multi_queue_en(mq), .port_speed_10m(spd),
      .class3_rate_kbps(c3), .class2_rate_kbps(c2), .diag_start(dgs), .diag_done(done),
      .diag_result(res), .diag_near_short(nshort), .diag_fault_count(fcnt),
      .force_link_pass(flp), .power_save_en(pse), .remote_loopback(rlb));
   always #5 clk = ~clk;
   task automatic chk(input string nm, input logic [16:0] x, input logic [16:0] got);
      checks++;
      if (got !== x)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, x, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      if (!w)
         chk($sformatf("reg %h", a), {9'h000, d}, {9'h000, rdata});
   endtask
   task automatic pulse(input logic [1:0] d, input logic [3:0] r, input logic [1:0] s,
                        input logic [17:0] f);
      @(posedge clk);
      done <= d;
      res <= r;
      nshort <= s;
      fcnt <= f;
      @(posedge clk);
      done <= 2'h0;
   endtask
   task automatic complete_run;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   //////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      xfer(1'b0, 8'h19, 8'h00);
      xfer(1'b0, 8'h2a, 8'h04);
      xfer(1'b0, 8'h1b, 8'h00);
      chk("power save", 17'h00000, {15'h0000, pse});
      chk("loopback", 17'h00000, {15'h0000, rlb});
      chk("link pass", 17'h00000, {15'h0000, flp});
      chk("test running", 17'h00000, {15'h0000, dgs});
      chk("mgmt copy", 17'h00404, {1'b0, mrd});
      $display("end reset");
      for (int s = 0; s < 2; s++)
      begin
         @(posedge clk);
         spd <= {2'h0, s[0]};
         for (int c = 0; c < 16; c++)
         begin
            xfer(1'b1, 8'h19, {c[3:0], c[3:0]});
            repeat (2) @(posedge clk);
            #1;
            e = (s == 1 && c > 8) ? 17'h00000 : rt[c];
            chk("class3 rate", e, c3[16:0]);
            chk("class2 rate", e, c2[16:0]);
         end
      end
      xfer(1'b1, 8'h19, 8'h55);
      @(posedge clk);
      mq <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("single queue rate", 17'h00000, c3[16:0]);
      chk("single queue rate", 17'h00000, c2[16:0]);
      @(posedge clk);
      mq <= 1'b1;
      $display("end rates");
      xfer(1'b1, 8'h39, 8'hf1);
      xfer(1'b1, 8'h3a, 8'hff);
      xfer(1'b0, 8'h3a, 8'h00);
      chk("port3 rate", rt[15], c3[50:34]);
      $display("end port3");
      xfer(1'b1, 8'h1a, 8'h14);
      xfer(1'b1, 8'h1a, 8'he5);
      xfer(1'b0, 8'h1a, 8'h14);
      chk("test running", 17'h00001, {15'h0000, dgs});
      pulse(2'h1, 4'h2, 2'h1, 18'h001a5);
      xfer(1'b0, 8'h1a, 8'hc5);
      chk("test running", 17'h00000, {15'h0000, dgs});
      xfer(1'b0, 8'h1b, 8'ha5);
      xfer(1'b1, 8'h1a, 8'h2a);
      xfer(1'b0, 8'h1a, 8'hcb);
      chk("power save", 17'h00001, {15'h0000, pse});
      chk("loopback", 17'h00001, {15'h0000, rlb});
      chk("link pass", 17'h00001, {15'h0000, flp});
      for (int r = 0; r < 4; r++)
      begin
         xfer(1'b1, 8'h2a, 8'h14);
         pulse(2'h2, {r[1:0], 2'h0}, 2'h0, 18'h00000);
         xfer(1'b0, 8'h2a, {1'b0, r[1:0], 5'h04});
      end
      $display("end cable test");
      @(posedge clk);
      mwr <= 2'h2;
      mwdata <= 16'h0a00;
      @(posedge clk);
      mwr <= 2'h0;
      xfer(1'b0, 8'h2a, 8'h6a);
      chk("mgmt copy", 17'h06acb, {1'b0, mrd});
      chk("power save", 17'h00003, {15'h0000, pse});
      chk("loopback", 17'h00003, {15'h0000, rlb});
      chk("link pass", 17'h00003, {15'h0000, flp});
      $display("end management");
      complete_run;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      $display("[FAIL] run expected done seen timeout");
      complete_run;
   end
endmodule
`default_nettype wire
